// [ssg_axis_model.sv]
// axis model: speed feedback of two drive axes and their braked stop reaction
// assumes the bench sets the commanded speed and whether monitoring is wanted
`timescale 1ns/1ps
module ssg_axis_model (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// bench side
	input  wire logic signed [31:0] cmd_speed,
	input  wire logic               req_on,
	// device side
	input  wire logic [1:0]         braked_stop_request,
	output logic signed [31:0]      speed_first_axis,
	output logic signed [31:0]      speed_second_axis,
	output logic                    monitor_request_n
);
	// low level asks for monitoring
	assign monitor_request_n = !req_on;

	// a braking axis halves its speed each cycle instead of following the command
	always_ff @(posedge clk) begin
		if (!nrst) begin
			speed_first_axis  <= '0;
			speed_second_axis <= '0;
		end else begin
			speed_first_axis  <= braked_stop_request[0] ? speed_first_axis >>> 1 : cmd_speed;
			speed_second_axis <= braked_stop_request[1] ? speed_second_axis >>> 1 : cmd_speed;
		end
	end
endmodule : ssg_axis_model

// [ssg_pkg.sv]
// constants, register map and carrier types of the speed ceiling guard
// assumes a single 250 MHz clock and a byte-addressed plain register port
package ssg_pkg;
	// timing
	localparam int CLK_NS          = 4;
	localparam int TICK_MS         = 1;
	localparam int NS_PER_MS       = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_MS * NS_PER_MS / CLK_NS;
	localparam int MS_W            = 17;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DELAY  = 8'h04;
	localparam logic [7:0] OFS_LIMIT  = 8'h08;
	localparam logic [7:0] OFS_PCT    = 8'h0c;
	localparam logic [7:0] OFS_WIDTH  = 8'h10;
	localparam logic [7:0] OFS_PERIOD = 8'h14;
	localparam logic [7:0] OFS_STATE  = 8'h18;
	localparam logic [7:0] OFS_STS    = 8'h1c;
	localparam logic [7:0] OFS_MASK   = 8'h20;

	// control field positions
	localparam int CTRL_PERM   = 0;
	localparam int CTRL_REPORT = 1;
	localparam int CTRL_AXIS   = 2;
	localparam int CTRL_TOL    = 3;
	localparam int CTRL_CLEAR  = 4;

	// values after reset, and the full percent scale
	localparam logic [MS_W-1:0] DELAY_RST  = 17'h00014;
	localparam logic [23:0]     LIMIT_RST  = 24'h0186a0;
	localparam logic [4:0]      PCT_RST    = 5'h01;
	localparam logic [MS_W-1:0] WIDTH_RST  = 17'h00064;
	localparam logic [MS_W-1:0] PERIOD_RST = 17'h003e8;
	localparam logic [6:0]      PCT_FULL   = 7'h64;

	typedef struct packed {
		logic            permanent;
		logic            report_only;
		logic            axis_sel;
		logic            tol_en;
		logic [MS_W-1:0] on_delay;
		logic [23:0]     limit;
		logic [4:0]      tol_pct;
		logic [MS_W-1:0] width_max;
		logic [MS_W-1:0] period_min;
	} ssg_cfg_t;

	typedef struct packed {
		logic overshoot;
		logic armed;
		logic fault;
	} ssg_evt_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_ARMED = 4'b0100,
		ST_FAULT = 4'b1000
	} ssg_state_t;
endpackage : ssg_pkg

// [ssg_speed_ceiling_guard.sv]
// speed ceiling guard: arming delay, limit compare, tolerance window, status
// assumes speed inputs and request pin are synchronous to clk
//
// Notes on behaviour
// [R1] report-only variant never requests a braked stop
// [R2] request input low activates, high deactivates
// [R3] permanent mode ignores request, skips arming delay
// [R4] compare only after arming delay has expired
// [R5] delay expires on next tick boundary
// [R6] armed: compare speed with limit every cycle
// [R7] normal overshoot: stop request, range ok low
// [R8] range ok high only while armed and within
// [R9] stop goes to first or second axis
// [R10] tolerance widens the effective limit
// [R11] tolerance evaluation starts at first overshoot
// [R12] beyond tolerance: stop request, range ok low
// [R13] tolerance margin held as percent of limit
// [R14] overshoot may last at most width maximum
// [R15] overshoots spaced at least period minimum
// [R16] tolerate: below margin, short, widely spaced
// [R17] compare magnitude, both directions alike
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module ssg_speed_ceiling_guard
	import ssg_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// register port
	input  wire logic [7:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic      [31:0]        rdata,
	// axis side
	input  wire logic signed [31:0] speed_first_axis,
	input  wire logic signed [31:0] speed_second_axis,
	input  wire logic               monitor_request_n,
	// outputs
	output logic                    range_ok_out,
	output logic      [1:0]         braked_stop_request,
	output logic                    irq
);

	ssg_cfg_t        cfg_q;
	ssg_state_t      state_q, state_d;
	ssg_evt_t        sts_q, mask_q, evt, sts_d;
	logic [31:0]     div_q;
	logic            tick_q;
	logic [MS_W-1:0] dcnt_q, width_q, since_q;
	logic            over_q, hard_q, over_prev_q, seen_q;
	logic            active, viol, over_rise, clr_cmd;
	logic [31:0]     mag;
	logic [39:0]     scaled_speed, scaled_lim;

	assign active  = cfg_q.permanent | ~monitor_request_n; // [R2] [R3]
	assign clr_cmd = wr && addr == OFS_CTRL && wdata[CTRL_CLEAR];

	////////////////////////////////////////////////////////////////////////
	// millisecond tick
	always_ff @(posedge clk) begin
		if (!nrst) begin
			div_q  <= 32'h0;
			tick_q <= 1'b0;
		end else if (div_q == 32'(TICK_CYCLES - 1)) begin
			div_q  <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_q <= '{permanent: 1'b0, report_only: 1'b0, axis_sel: 1'b0, tol_en: 1'b0,
				on_delay: DELAY_RST, limit: LIMIT_RST, tol_pct: PCT_RST,
				width_max: WIDTH_RST, period_min: PERIOD_RST};
		end else if (wr) begin
			unique case (addr)
				OFS_CTRL: begin
					cfg_q.permanent   <= wdata[CTRL_PERM];
					cfg_q.report_only <= wdata[CTRL_REPORT];
					cfg_q.axis_sel    <= wdata[CTRL_AXIS];   // [R9]
					cfg_q.tol_en      <= wdata[CTRL_TOL];    // [R10]
				end
				OFS_DELAY:  cfg_q.on_delay   <= wdata[MS_W-1:0];
				OFS_LIMIT:  cfg_q.limit      <= wdata[23:0];
				OFS_PCT:    cfg_q.tol_pct    <= wdata[4:0];   // [R13]
				OFS_WIDTH:  cfg_q.width_max  <= wdata[MS_W-1:0]; // [R14]
				OFS_PERIOD: cfg_q.period_min <= wdata[MS_W-1:0]; // [R15]
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// speed compare, one register stage
	always_comb begin
		mag = cfg_q.axis_sel ? speed_second_axis : speed_first_axis;
		if (mag[31])
			mag = 32'(-mag); // [R17]
		scaled_speed = 40'(mag) * 40'(PCT_FULL);
		scaled_lim   = 40'(cfg_q.limit) * (40'(PCT_FULL) + 40'(cfg_q.tol_pct)); // [R10] [R13]
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			over_q      <= 1'b0;
			hard_q      <= 1'b0;
			over_prev_q <= 1'b0;
		end else begin
			over_q      <= mag > 32'(cfg_q.limit); // [R6]
			hard_q      <= scaled_speed > scaled_lim; // [R16]
			over_prev_q <= over_q;
		end
	end

	assign over_rise = over_q & ~over_prev_q; // [R11]

	// tolerance only forgives a bounded width and spacing of overshoots
	always_comb begin
		if (!cfg_q.tol_en)
			viol = over_q; // [R7]
		else
			viol = hard_q | (over_q && width_q > cfg_q.width_max)
				| (over_rise && seen_q && since_q < cfg_q.period_min); // [R12] [R16]
	end

	////////////////////////////////////////////////////////////////////////
	// tolerance timers, run only while armed
	always_ff @(posedge clk) begin
		if (!nrst || state_q != ST_ARMED) begin
			width_q <= '0;
			since_q <= '0;
			seen_q  <= 1'b0;
		end else begin
			if (!over_q)
				width_q <= '0;
			else if (tick_q && width_q != '1)
				width_q <= width_q + 1'b1; // [R14]
			if (over_rise) begin
				since_q <= '0;
				seen_q  <= 1'b1; // [R15]
			end else if (tick_q && since_q != '1) begin
				since_q <= since_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// arming sequence
	always_ff @(posedge clk) begin
		if (!nrst || state_q != ST_DELAY)
			dcnt_q <= '0;
		else if (tick_q)
			dcnt_q <= dcnt_q + 1'b1;
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
				if (active)
					state_d = cfg_q.permanent ? ST_ARMED : ST_DELAY; // [R3]
			ST_DELAY:
				if (!active)
					state_d = ST_IDLE;
				else if (tick_q && dcnt_q == cfg_q.on_delay)
					state_d = ST_ARMED; // [R4] [R5]
			ST_ARMED:
				if (!active)
					state_d = ST_IDLE;
				else if (viol)
					state_d = ST_FAULT; // [R6]
			ST_FAULT:
				if (!active)
					state_d = ST_IDLE;
				else if (clr_cmd)
					state_d = ST_ARMED;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			range_ok_out        <= 1'b0;
			braked_stop_request <= 2'h0;
		end else begin
			// an overshoot already present at arming must not flash a good ack
			range_ok_out <= state_d == ST_ARMED && !viol; // [R8]
			// report-only keeps the axis running, only the ack drops
			braked_stop_request[0] <= state_d == ST_FAULT && !cfg_q.report_only && !cfg_q.axis_sel; // [R1] [R9]
			braked_stop_request[1] <= state_d == ST_FAULT && !cfg_q.report_only && cfg_q.axis_sel;  // [R1] [R9]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status, set wins over write-one clear
	always_comb begin
		evt.fault     = state_q == ST_ARMED && state_d == ST_FAULT;
		evt.armed     = state_q != ST_ARMED && state_d == ST_ARMED;
		evt.overshoot = state_q == ST_ARMED && over_rise && cfg_q.tol_en;
		sts_d = sts_q;
		if (wr && addr == OFS_STS)
			sts_d = sts_d & ~ssg_evt_t'(wdata[2:0]);
		sts_d = sts_d | evt;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sts_q  <= '0;
			mask_q <= '0;
			irq    <= 1'b0;
		end else begin
			sts_q <= sts_d;
			if (wr && addr == OFS_MASK)
				mask_q <= ssg_evt_t'(wdata[2:0]);
			irq <= |(sts_d & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, valid only the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!nrst || !rd) begin
			rdata <= 32'h0;
		end else begin
			unique case (addr)
				OFS_CTRL:   rdata <= {28'h0, cfg_q.tol_en, cfg_q.axis_sel, cfg_q.report_only, cfg_q.permanent};
				OFS_DELAY:  rdata <= 32'(cfg_q.on_delay);
				OFS_LIMIT:  rdata <= 32'(cfg_q.limit);
				OFS_PCT:    rdata <= 32'(cfg_q.tol_pct);
				OFS_WIDTH:  rdata <= 32'(cfg_q.width_max);
				OFS_PERIOD: rdata <= 32'(cfg_q.period_min);
				OFS_STATE:  rdata <= {24'h0, over_q, active, 2'h0, state_q};
				OFS_STS:    rdata <= 32'(sts_q);
				OFS_MASK:   rdata <= 32'(mask_q);
				default:    rdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_ok_only_armed: assert property (range_ok_out |-> state_q == ST_ARMED) // [R8]
		else $error("range ok high outside armed state");
	a_report_no_stop: assert property ((|braked_stop_request) |-> !$past(cfg_q.report_only)) // [R1]
		else $error("stop requested in report-only mode");
	a_over_stops: assert property (state_q == ST_ARMED && over_q && !cfg_q.tol_en && active
		&& !cfg_q.report_only |=> braked_stop_request != 2'h0 && !range_ok_out) // [R7]
		else $error("overshoot without stop request");
	a_over_faults: assert property (state_q == ST_ARMED && over_q && !cfg_q.tol_en && active
		|=> state_q == ST_FAULT) // [R6]
		else $error("overshoot not detected");
	a_perm_skip: assert property (state_q == ST_IDLE && cfg_q.permanent |=> state_q == ST_ARMED) // [R3]
		else $error("permanent mode did not arm at once");
	a_req_delay: assert property (state_q == ST_IDLE && !cfg_q.permanent && !monitor_request_n
		|=> state_q == ST_DELAY && !range_ok_out) // [R2]
		else $error("request did not start arming delay");
	a_delay_bound: assert property (state_q == ST_ARMED && $past(state_q) == ST_DELAY
		|-> $past(tick_q) && $past(dcnt_q) == $past(cfg_q.on_delay)) // [R4] [R5]
		else $error("armed before delay expiry");
	a_axis_route: assert property (braked_stop_request[1] |-> $past(cfg_q.axis_sel)
		&& !braked_stop_request[0]) // [R9]
		else $error("stop routed to wrong axis");
	a_hard_margin: assert property (state_q == ST_ARMED && cfg_q.tol_en && hard_q && active
		|=> state_q == ST_FAULT && !range_ok_out) // [R12]
		else $error("overshoot beyond margin tolerated");
	a_width_limit: assert property (state_q == ST_ARMED && cfg_q.tol_en && over_q && active
		&& width_q > cfg_q.width_max |=> state_q == ST_FAULT) // [R14]
		else $error("overshoot too long tolerated");
	a_period_space: assert property (state_q == ST_ARMED && cfg_q.tol_en && over_rise && seen_q && active
		&& since_q < cfg_q.period_min |=> state_q == ST_FAULT) // [R15]
		else $error("overshoots too close tolerated");
	a_stop_in_fault: assert property ((|braked_stop_request) |-> state_q == ST_FAULT) // [R7]
		else $error("stop requested outside fault state");

endmodule : ssg_speed_ceiling_guard

// [ssg_speed_ceiling_guard_tb.sv]
// self-checking bench of the speed ceiling guard with the axis model
// assumes a shortened tick of 4 cycles so one ms lasts 16 ns
`timescale 1ns/1ps
module ssg_speed_ceiling_guard_tb;
	import ssg_pkg::*;
	typedef struct packed {
		logic [3:0]         ctrl;
		logic [16:0]        width;
		logic signed [31:0] speed;
		logic               ok;
		logic [1:0]         stop;
	} ssg_row_t;
	localparam ssg_row_t ROWS [8] = '{
		'{4'h0, 17'h00064, 32'sd100000, 1'b1, 2'b00},
		'{4'h0, 17'h00064, 32'sd100001, 1'b0, 2'b01},
		'{4'h0, 17'h00064, -32'sd100001, 1'b0, 2'b01},
		'{4'h4, 17'h00064, 32'sd100001, 1'b0, 2'b10},
		'{4'h2, 17'h00064, 32'sd100001, 1'b0, 2'b00},
		'{4'h8, 17'h00064, 32'sd100500, 1'b1, 2'b00},
		'{4'h8, 17'h00064, 32'sd101001, 1'b0, 2'b01},
		'{4'h8, 17'h00002, 32'sd100500, 1'b0, 2'b01}
	};
	logic               clk;
	logic               nrst;
	logic [7:0]         addr;
	logic [31:0]        wdata;
	logic               wr;
	logic               rd;
	logic [31:0]        rdata;
	logic signed [31:0] spd1;
	logic signed [31:0] spd2;
	logic signed [31:0] cmd;
	logic               req_on;
	logic               req_n;
	logic               ok;
	logic [1:0]         stop;
	logic               irq;
	logic [31:0]        v;
	int                 errors;
	int                 total_checks;
	int                 cycles;
	int                 n;

	ssg_speed_ceiling_guard #(.TICK_CYCLES(4)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .speed_first_axis(spd1), .speed_second_axis(spd2),
		.monitor_request_n(req_n), .range_ok_out(ok), .braked_stop_request(stop), .irq(irq));
	ssg_axis_model axis (.clk(clk), .nrst(nrst), .cmd_speed(cmd), .req_on(req_on),
		.braked_stop_request(stop), .speed_first_axis(spd1), .speed_second_axis(spd2),
		.monitor_request_n(req_n));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// ceiling well above the roughly 1100 cycles the tests need
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		nrst = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
		cmd = '0; req_on = 1'b0; errors = 0; total_checks = 0;
		repeat (10) @(posedge clk);
		check("reset outputs", {28'h0, irq, ok, stop}, 32'h0);
		nrst <= 1'b1;
		rd_reg(OFS_LIMIT, v);
		check("limit reset", v, 32'h000186a0);
		rd_reg(OFS_DELAY, v);
		check("delay reset", v, 32'h00000014);
		$display("reset test done");

		for (int i = 0; i < 8; i++) begin
			wr_reg(OFS_WIDTH, {15'h0, ROWS[i].width});
			wr_reg(OFS_CTRL, {28'h1, ROWS[i].ctrl});
			cmd    <= ROWS[i].speed;
			req_on <= 1'b1;
			repeat (120) @(posedge clk);
			check("range ok", {31'h0, ok}, {31'h0, ROWS[i].ok});
			check("stop", {30'h0, stop}, {30'h0, ROWS[i].stop});
			check("irq masked", {31'h0, irq}, 32'h0);
			req_on <= 1'b0;
			cmd    <= '0;
			repeat (4) @(posedge clk);
			check("inactive ok", {29'h0, ok, stop}, 32'h0);
			$display("row %0d done", i);
		end

		// two ms delay must not arm before eight cycles, nor later than sixteen cycles
		wr_reg(OFS_DELAY, 32'h2);
		wr_reg(OFS_CTRL, 32'h10);
		@(posedge clk);
		req_on <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ok !== 1'b1 && n < 40);
		check("arm window", {31'h0, n >= 8 && n <= 16}, 32'h1);
		req_on <= 1'b0;
		repeat (4) @(posedge clk);
		$display("delay test done");

		wr_reg(OFS_CTRL, 32'h11);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ok !== 1'b1 && n < 40);
		check("permanent arm", {31'h0, n < 8}, 32'h1);
		wr_reg(OFS_CTRL, 32'h10);
		$display("permanent test done");

		wr_reg(OFS_MASK, 32'h1);
		@(posedge clk);
		#1 check("irq raised", {31'h0, irq}, 32'h1);
		wr_reg(OFS_STS, 32'h1);
		@(posedge clk);
		#1 check("irq cleared", {31'h0, irq}, 32'h0);
		rd_reg(8'h40, v);
		check("unmapped read", v, 32'h0);
		$display("irq test done");

		// second overshoot too soon after the first must fault the axis
		wr_reg(OFS_PERIOD, 32'h5);
		wr_reg(OFS_CTRL, 32'h19);
		repeat (4) @(posedge clk);
		check("tol armed", {31'h0, ok}, 32'h1);
		cmd <= 32'sd100500;
		repeat (4) @(posedge clk);
		check("single overshoot", {30'h0, ok, stop[0]}, 32'h2);
		cmd <= '0;
		repeat (4) @(posedge clk);
		cmd <= 32'sd100500;
		repeat (4) @(posedge clk);
		check("period fault", {30'h0, ok, stop[0]}, 32'h1);
		cmd <= '0;
		rd_reg(OFS_STS, v);
		check("status bits", v, 32'h7);
		check("irq fault", {31'h0, irq}, 32'h1);
		wr_reg(OFS_CTRL, 32'h19);
		repeat (2) @(posedge clk);
		check("fault clear", {30'h0, ok, stop[0]}, 32'h2);
		rd_reg(OFS_STATE, v);
		check("state reg", v, 32'h44);
		$display("period test done");

		// reset in mid-run returns outputs and settings to their reset values
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		check("mid reset outputs", {28'h0, irq, ok, stop}, 32'h0);
		nrst <= 1'b1;
		rd_reg(OFS_CTRL, v);
		check("mid reset ctrl", v, 32'h0);
		rd_reg(OFS_WIDTH, v);
		check("mid reset width", v, 32'h00000064);
		check("idle after reset", {31'h0, ok}, 32'h0);
		$display("mid reset test done");
		report_and_stop();
	end
endmodule : ssg_speed_ceiling_guard_tb
